/* File: pkg/flash_self_program_pkg.sv */
// Constants, types and field layout for the flash self-programming controller.
package flash_self_program_pkg;

  // Register placement.
  localparam logic [7:0] CSR_DATA_ADDR = 8'h57;
  localparam logic [7:0] IO_OFFSET     = 8'h20;
  localparam logic [7:0] CSR_IO_ADDR   = 8'h37;
  localparam logic [7:0] CSR_RESET     = 8'h00;

  // Control register bit positions.
  localparam int BIT_IRQ_EN   = 7;
  localparam int BIT_BUSY     = 6;
  localparam int BIT_SIG      = 5;
  localparam int BIT_REEN     = 4;
  localparam int BIT_LOCK     = 3;
  localparam int BIT_PGWR     = 2;
  localparam int BIT_PGER     = 1;
  localparam int BIT_STORE_PROG_ENABLE    = 0;

  // Legal low-five-bit command codes.
  localparam logic [4:0] CMD_FILL  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_LOCK  = 5'h09;
  localparam logic [4:0] CMD_REEN  = 5'h11;

  // Address geometry.
  localparam int PC_W       = 13;
  localparam int WORD_W     = 6;
  localparam int PAGE_W     = 7;
  localparam int PAGE_WORDS = 64;
  localparam logic [PAGE_W-1:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h70;
  localparam logic [12:0] RWW_LAST_ADDR = 13'h1BFF;

  // Boot section start addresses by fuse code.
  localparam logic [12:0] BOOT_START_11 = 13'h1F80;
  localparam logic [12:0] BOOT_START_10 = 13'h1F00;
  localparam logic [12:0] BOOT_START_01 = 13'h1E00;
  localparam logic [12:0] BOOT_START_00 = 13'h1C00;

  // Window lengths in core cycles.
  localparam logic [2:0] STORE_WINDOW = 3'h4;
  localparam logic [2:0] LOAD_WINDOW  = 3'h3;

  // Programming time in microseconds, and the core clock.
  localparam int PROG_MIN_US  = 3200;
  localparam int PROG_MAX_US  = 3400;
  localparam int CLK_MHZ      = 40;
  localparam int PROG_CYCLES  = PROG_MIN_US * CLK_MHZ;

  // Sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_OPEN = 2'b01,
    ST_BUSY = 2'b10
  } seq_state_t;

  // Store request from the core.
  typedef struct packed {
    logic        valid;
    logic [15:0] pointer;
    logic [15:0] data;
  } store_req_t;

  // Command toward the flash array.
  typedef struct packed {
    logic              erase;
    logic              write;
    logic              lock;
    logic [PAGE_W-1:0] page;
    logic [7:0]        lock_val;
  } flash_cmd_t;

endpackage : flash_self_program_pkg

/* File: src/flash_self_program_ctrl.sv */
// Flash self-programming sequencer with temporary page buffer and control register.
`timescale 1ns/1ps
`default_nettype none

module flash_self_program_ctrl
  import flash_self_program_pkg::*;
#(
  parameter int PROG_TIME_CYCLES = PROG_CYCLES
) (
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        resetn,
  // Core register access.
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        reg_io_space,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        global_irq_enable,
  // Store and load program-memory instructions.
  input  wire store_req_t  store_req,
  input  wire logic        load_req,
  input  wire logic [15:0] load_pointer,
  output logic      [7:0]  load_data,
  output logic             load_special,
  // Fuses and stored lock and signature values.
  input  wire logic [1:0]  boot_size_fuse,
  input  wire logic [7:0]  fuse_low,
  input  wire logic [7:0]  fuse_high,
  input  wire logic [7:0]  signature_byte,
  // Flash array side.
  output flash_cmd_t       flash_cmd,
  output logic             flash_cmd_valid,
  output logic      [15:0] buffer_word,
  input  wire logic [WORD_W-1:0] buffer_index,
  // Status toward the core.
  output logic             prog_ready_irq,
  output logic             readable_section_busy,
  output logic             core_halt,
  output logic      [12:0] boot_start_addr,
  output logic      [7:0]  lock_bits
);

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // Boot start address for a fuse code.
  function automatic logic [12:0] boot_start(input logic [1:0] code);
    case (code)
      2'b11:   boot_start = BOOT_START_11;
      2'b10:   boot_start = BOOT_START_10;
      2'b01:   boot_start = BOOT_START_01;
      default: boot_start = BOOT_START_00;
    endcase
  endfunction

  // Page number from the pointer; bits 15..14 and 6..0 play no part.
  function automatic logic [PAGE_W-1:0] page_of(input logic [15:0] ptr);
    page_of = ptr[PAGE_W+WORD_W:WORD_W+1];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic             irq_en;       // Ready interrupt enable.
  logic             busy;         // Readable section busy flag.
  logic [4:0]       cmd;          // Latched command bits.
  logic             sig_rd;       // Signature read armed.
  logic [2:0]       win_cnt;      // Cycles left in the open window.
  logic [2:0]       load_cnt;     // Cycles left for a special load.
  logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt; // Programming timer.
  seq_state_t       state;        // Sequencer state.
  logic [15:0]      page_buf [PAGE_WORDS]; // Temporary page buffer.
  logic             buf_loading;  // Buffer holds partial fill data.
  logic             busy_is_no_read_while_write_section; // Running operation targets protected pages.

  // Decoded register access, in either address space.
  logic csr_hit;
  assign csr_hit = reg_io_space ? (reg_addr == CSR_IO_ADDR)
                                : (reg_addr == CSR_DATA_ADDR);

  // Command write with a defined low-five-bit code.
  logic cmd_legal;
  always_comb begin
    case (reg_wdata[4:0])
      CMD_FILL, CMD_ERASE, CMD_WRITE, CMD_LOCK, CMD_REEN: cmd_legal = 1'b1;
      default: cmd_legal = 1'b0;
    endcase
  end

  logic cmd_write;
  assign cmd_write = reg_wr && csr_hit && cmd_legal && (state == ST_IDLE);

  // Store accepted inside an open window unless a signature read is armed; otherwise nothing happens.
  logic store_take;
  assign store_take = store_req.valid && (state == ST_OPEN) && !sig_rd;

  logic store_prog_enable;
  assign store_prog_enable = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt enable bit, written by software at any time.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_en <= CSR_RESET[BIT_IRQ_EN];
    end else if (reg_wr && csr_hit) begin
      irq_en <= reg_wdata[BIT_IRQ_EN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: window, programming timer and self-clearing command bits.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state    <= ST_IDLE;
      cmd      <= CSR_RESET[4:0];
      sig_rd   <= 1'b0;
      win_cnt  <= '0;
      prog_cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_write) begin
            // Writing a legal code opens the four-cycle window.
            state   <= ST_OPEN;
            cmd     <= reg_wdata[4:0];
            sig_rd  <= reg_wdata[BIT_SIG] && (reg_wdata[4:0] == CMD_FILL);
            win_cnt <= STORE_WINDOW - 3'h1;
          end
        end
        ST_OPEN: begin
          if (store_take && (cmd == CMD_ERASE || cmd == CMD_WRITE || cmd == CMD_LOCK)) begin
            // Timed operations keep store enable high until done.
            state    <= ST_BUSY;
            prog_cnt <= PROG_TIME_CYCLES[$bits(prog_cnt)-1:0];
          end else if (store_take || win_cnt == 3'h0) begin
            // Window used or expired: all command bits self-clear.
            state  <= ST_IDLE;
            cmd    <= '0;
            sig_rd <= 1'b0;
          end else begin
            win_cnt <= win_cnt - 3'h1;
          end
        end
        ST_BUSY: begin
          if (prog_cnt <= 1) begin
            state <= ST_IDLE;
            cmd   <= '0;
          end else begin
            prog_cnt <= prog_cnt - 1'b1;
          end
        end
        default: begin
          state <= ST_IDLE;
          cmd   <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readable section busy flag; a set in the same cycle as a clear wins.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      busy         <= 1'b0;
      busy_is_no_read_while_write_section <= 1'b0;
    end else if (store_take && (cmd == CMD_ERASE || cmd == CMD_WRITE)) begin
      busy_is_no_read_while_write_section <= (page_of(store_req.pointer) >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
      if (page_of(store_req.pointer) < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE) begin
        busy <= 1'b1;
      end
    end else if (store_take && cmd == CMD_REEN) begin
      busy <= 1'b0;
    end else if (store_take && cmd == CMD_FILL) begin
      busy <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Temporary page buffer fill and abort.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      buf_loading <= 1'b0;
    end else if (cmd_write && reg_wdata[4:0] == CMD_REEN && buf_loading) begin
      buf_loading <= 1'b0;
    end else if (store_take && cmd == CMD_FILL) begin
      buf_loading <= 1'b1;
    end else if (state == ST_BUSY && cmd == CMD_WRITE) begin
      buf_loading <= 1'b0;
    end
  end

  // Buffer memory; an abort wipes it back to the erased value.
  always_ff @(posedge sys_clk) begin
    if (cmd_write && reg_wdata[4:0] == CMD_REEN && buf_loading) begin
      for (int i = 0; i < PAGE_WORDS; i++) begin
        page_buf[i] <= 16'hFFFF;
      end
    end else if (store_take && cmd == CMD_FILL) begin
      // Word picked by pointer bits 6..1; bit 0 ignored.
      page_buf[store_req.pointer[WORD_W:1]] <= store_req.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash array commands and stored lock bits.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flash_cmd       <= '0;
      flash_cmd_valid <= 1'b0;
      lock_bits       <= 8'hFF;
      buffer_word     <= 16'h0000;
    end else begin
      buffer_word     <= page_buf[buffer_index];
      flash_cmd_valid <= 1'b0;
      if (store_take && cmd != CMD_FILL && cmd != CMD_REEN) begin
        flash_cmd.erase    <= (cmd == CMD_ERASE);
        flash_cmd.write    <= (cmd == CMD_WRITE);
        flash_cmd.lock     <= (cmd == CMD_LOCK);
        flash_cmd.page     <= page_of(store_req.pointer);
        flash_cmd.lock_val <= store_req.data[7:0];
        flash_cmd_valid    <= 1'b1;
        if (cmd == CMD_LOCK) begin
          lock_bits <= store_req.data[7:0];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Special loads of lock, fuse or signature bytes within three cycles.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      load_cnt     <= '0;
      load_data    <= 8'h00;
      load_special <= 1'b0;
    end else begin
      load_special <= 1'b0;
      if (cmd_write && (reg_wdata[4:0] == CMD_LOCK || reg_wdata[BIT_SIG])) begin
        load_cnt <= LOAD_WINDOW;
      end else if (load_cnt != 3'h0) begin
        load_cnt <= load_cnt - 3'h1;
        if (load_req) begin
          load_special <= 1'b1;
          load_cnt     <= '0;
          if (sig_rd) begin
            load_data <= signature_byte;
          end else begin
            load_data <= load_pointer[0] ? fuse_high : lock_bits;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status outputs, register read-back and fuse-derived boot start.
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      reg_rdata             <= CSR_RESET;
      prog_ready_irq        <= 1'b0;
      readable_section_busy <= 1'b0;
      core_halt             <= 1'b0;
      boot_start_addr       <= BOOT_START_00;
    end else begin
      reg_rdata <= (reg_rd && csr_hit) ?
                   {irq_en, busy, sig_rd, cmd[4:1], store_prog_enable} : 8'h00;
      prog_ready_irq        <= irq_en && global_irq_enable && !store_prog_enable;
      readable_section_busy <= busy;
      core_halt             <= (state == ST_BUSY) && busy_is_no_read_while_write_section &&
                               (cmd == CMD_ERASE || cmd == CMD_WRITE);
      boot_start_addr       <= boot_start(boot_size_fuse);
    end
  end

endmodule : flash_self_program_ctrl

`default_nettype wire

/* File: dv/flash_self_program_props.sv */
// Concurrent checks on the ports of the flash self-programming controller.
`timescale 1ns/1ps
`default_nettype none
module flash_self_program_props
  import flash_self_program_pkg::*;
(
  // Clock and reset.
  input wire logic        sys_clk,
  input wire logic        resetn,
  // Core side.
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        global_irq_enable,
  input wire store_req_t  store_req,
  input wire logic        load_req,
  input wire logic        load_special,
  input wire logic [1:0]  boot_size_fuse,
  // Flash side and status.
  input wire flash_cmd_t  flash_cmd,
  input wire logic        flash_cmd_valid,
  input wire logic        prog_ready_irq,
  input wire logic        readable_section_busy,
  input wire logic        core_halt,
  input wire logic [12:0] boot_start_addr
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // An erase or write command leaving toward the array.
  wire logic pg = flash_cmd_valid && (flash_cmd.erase || flash_cmd.write);
  ////////////////////////////////////////////////////////////////////////////////
  a_cmd_one_pulse: assert property (flash_cmd_valid |=> !flash_cmd_valid)
    else $error("command pulse longer than one cycle");
  a_cmd_after_store: assert property (flash_cmd_valid |-> $past(store_req.valid))
    else $error("command without a store");
  a_page_from_ptr: assert property (pg |-> flash_cmd.page == $past(store_req.pointer[13:7]))
    else $error("wrong page number");
  a_lock_from_low: assert property (flash_cmd_valid && flash_cmd.lock |->
    flash_cmd.lock_val == $past(store_req.data[7:0]))
    else $error("wrong lock value");
  a_busy_on_rww: assert property (pg && flash_cmd.page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE
    |-> ##[0:1] readable_section_busy)
    else $error("busy flag not set");
  a_halt_on_no_read_while_write_section: assert property (pg && flash_cmd.page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> ##[0:1] core_halt)
    else $error("core not halted");
  a_irq_needs_gie: assert property (!$past(global_irq_enable) |-> !prog_ready_irq)
    else $error("ready interrupt without global enable");
  a_boot_map: assert property ($past(resetn) |-> {1'b0, boot_start_addr}
    == 14'h2000 - (14'h0080 << ~$past(boot_size_fuse)))
    else $error("boot start mismatch");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data without read");
  a_special_load: assert property (load_special |-> $past(load_req))
    else $error("special load without a load");
  // Main scenarios reached.
  c_page_op: cover property (pg);
  c_lock_op: cover property (flash_cmd_valid && flash_cmd.lock);
  c_special: cover property (load_special);
endmodule // flash_self_program_props
bind flash_self_program_ctrl flash_self_program_props props_u (.sys_clk, .resetn, .reg_rd,
  .reg_rdata, .global_irq_enable, .store_req, .load_req, .load_special, .boot_size_fuse,
  .flash_cmd, .flash_cmd_valid, .prog_ready_irq, .readable_section_busy, .core_halt,
  .boot_start_addr);
`default_nettype wire

/* File: dv/core_model.sv */
// Behavioural processor core issuing store and load program-memory instructions.
`timescale 1ns/1ps
`default_nettype none
module core_model
  import flash_self_program_pkg::*;
(
  // Clock.
  input  wire logic   sys_clk,
  // Instruction requests.
  output store_req_t  store_req,
  output logic        load_req,
  output logic [15:0] load_pointer
);
  // Quiet at time zero.
  initial begin
    store_req = '0;
    load_req = 1'b0;
    load_pointer = 16'h0000;
  end
  // One store; the released fields show inverted values so nothing stale looks valid.
  task automatic store(input logic [15:0] ptr, input logic [15:0] dat);
    @(posedge sys_clk);
    #1;
    store_req = {1'b1, ptr, dat};
    @(posedge sys_clk);
    #1;
    store_req = {1'b0, ~ptr, ~dat};
  endtask
  // One load; bit 0 of the pointer selects the byte.
  task automatic load(input logic [15:0] ptr);
    @(posedge sys_clk);
    #1;
    load_req = 1'b1;
    load_pointer = ptr;
    @(posedge sys_clk);
    #1;
    load_req = 1'b0;
    load_pointer = ~ptr;
  endtask
endmodule // core_model
`default_nettype wire

/* File: dv/tb_flash_self_program_ctrl.sv */
// Self-checking bench for the flash self-programming controller.
`timescale 1ns/1ps
`default_nettype none
module tb_flash_self_program_ctrl;
  import flash_self_program_pkg::*;
  // Short programming time keeps the run brief.
  localparam int PT = 20;
  logic sys_clk, resetn, reg_wr, reg_rd, reg_io_space, global_irq_enable, load_req, load_special;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, load_data, lock_bits;
  logic [7:0] fuse_high, signature_byte; // Driven by the bench so the special loads see them.
  logic [15:0] load_pointer, buffer_word;
  logic [1:0] boot_size_fuse;
  logic [5:0] buffer_index;
  logic [12:0] boot_start_addr;
  logic flash_cmd_valid, prog_ready_irq, readable_section_busy, core_halt;
  store_req_t store_req;
  flash_cmd_t flash_cmd;
  int bad_count, n_tests, cycles;
  flash_self_program_ctrl #(.PROG_TIME_CYCLES(PT)) dut_u (.fuse_low(8'h5A), .*);
  core_model core_u (.sys_clk, .store_req, .load_req, .load_pointer);
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz, and a hang limit.
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      finish_test();
    end
  end
  // Verdict and end of run.
  task automatic finish_test();
    if (bad_count == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Register write and read, one strobe cycle each.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    #1;
    {reg_wr, reg_io_space, reg_addr, reg_wdata} = {2'b10, a, v};
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic io, output logic [7:0] v);
    @(posedge sys_clk);
    #1;
    {reg_rd, reg_io_space, reg_addr} = {1'b1, io, io ? CSR_IO_ADDR : CSR_DATA_ADDR};
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
  // Polls store enable until it clears; a long wait is a fault.
  task automatic idle_wait();
    logic [7:0] v;
    for (int i = 0; i < 40; i++) begin
      rd(1'b0, v);
      if (v[0] === 1'b0) break;
    end
    chk(v[0], 1'b0);
  endtask
  task automatic cmd_wait();
    for (int i = 0; i < 4 && flash_cmd_valid !== 1'b1; i++) @(posedge sys_clk) #1;
    chk(flash_cmd_valid, 1'b1);
  endtask
  task automatic ld_chk(input logic [7:0] exp);
    for (int i = 0; i < 4 && load_special !== 1'b1; i++) @(posedge sys_clk) #1;
    chk(load_data, exp);
    idle_wait();
  endtask
  task automatic buf_chk(input logic [5:0] i, input logic [15:0] exp);
    buffer_index = i;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(buffer_word, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Reset value, both address spaces, unmapped and illegal writes, boot map.
  task automatic t_regs();
    logic [7:0] v;
    rd(1'b0, v);
    chk(v, CSR_RESET);
    rd(1'b1, v);
    chk(v, CSR_RESET);
    chk(lock_bits, 8'hFF);
    wr(8'h58, CMD_ERASE);
    rd(1'b0, v);
    chk(v, 8'h00);
    wr(CSR_DATA_ADDR, 8'h07);
    rd(1'b1, v);
    chk(v, 8'h00);
    for (int f = 0; f < 4; f++) begin
      boot_size_fuse = f[1:0];
      repeat (2) @(posedge sys_clk);
      #1;
      chk(boot_start_addr, 16'h2000 - (16'h0080 << (3 - f)));
    end
  endtask
  // Fill, page write in the readable section, refused and real re-enable.
  task automatic t_page();
    logic [7:0] v;
    wr(CSR_DATA_ADDR, CMD_FILL);
    core_u.store(16'hC07F, 16'hBEEF);
    idle_wait();
    wr(CSR_DATA_ADDR, CMD_FILL);
    core_u.store(16'h0000, 16'h1234);
    idle_wait();
    buf_chk(6'h3F, 16'hBEEF);
    buf_chk(6'h00, 16'h1234);
    wr(CSR_DATA_ADDR, CMD_WRITE);
    core_u.store(16'h8280, 16'h5555);
    cmd_wait();
    chk(flash_cmd.write, 1'b1);
    chk(flash_cmd.page, 7'h05);
    @(posedge sys_clk) #1;
    chk(readable_section_busy, 1'b1);
    chk(core_halt, 1'b0);
    rd(1'b0, v);
    chk(v[0], 1'b1);
    wr(CSR_DATA_ADDR, CMD_REEN);
    core_u.store(16'h0000, 16'h0000);
    chk(readable_section_busy, 1'b1);
    idle_wait();
    wr(CSR_DATA_ADDR, CMD_REEN);
    core_u.store(16'h0000, 16'h0000);
    idle_wait();
    chk(readable_section_busy, 1'b0);
  endtask
  // Erase of a protected page halts the core and leaves the flag alone.
  task automatic t_erase();
    wr(CSR_DATA_ADDR, CMD_ERASE);
    core_u.store(16'h3800, 16'h0000);
    cmd_wait();
    chk(flash_cmd.page, 7'h70);
    @(posedge sys_clk) #1;
    chk(core_halt, 1'b1);
    chk(readable_section_busy, 1'b0);
    idle_wait();
    chk(core_halt, 1'b0);
  endtask
  // Buffer load clears busy; re-enable during loading wipes it; late store.
  task automatic t_abort();
    logic [7:0] v;
    wr(CSR_DATA_ADDR, CMD_WRITE);
    core_u.store(16'h0000, 16'h0000);
    idle_wait();
    wr(CSR_DATA_ADDR, CMD_FILL);
    core_u.store(16'h0002, 16'hA5A5);
    idle_wait();
    chk(readable_section_busy, 1'b0);
    wr(CSR_DATA_ADDR, CMD_REEN);
    core_u.store(16'h0000, 16'h0000);
    idle_wait();
    buf_chk(6'h01, 16'hFFFF);
    wr(CSR_DATA_ADDR, CMD_FILL);
    rd(1'b0, v);
    chk(v[0], 1'b1);
    repeat (4) @(posedge sys_clk);
    #1;
    core_u.store(16'h0004, 16'h0BAD);
    buf_chk(6'h02, 16'hFFFF);
  endtask
  // Lock write and the special loads.
  task automatic t_lock();
    wr(CSR_DATA_ADDR, CMD_LOCK);
    core_u.store(16'hFFFF, 16'h12C3);
    cmd_wait();
    chk(flash_cmd.lock_val, 8'hC3);
    idle_wait();
    chk(lock_bits, 8'hC3);
    wr(CSR_DATA_ADDR, CMD_LOCK);
    core_u.load(16'h0001);
    ld_chk(8'hA6);
    wr(CSR_DATA_ADDR, CMD_LOCK);
    core_u.load(16'h0000);
    ld_chk(8'hC3);
    wr(CSR_DATA_ADDR, 8'h21);
    core_u.load(16'h0000);
    ld_chk(8'h3C);
  endtask
  // Ready interrupt follows enable, global enable and store enable.
  task automatic t_irq();
    global_irq_enable = 1'b1;
    wr(CSR_DATA_ADDR, 8'h80);
    @(posedge sys_clk) #1;
    chk(prog_ready_irq, 1'b1);
    wr(CSR_DATA_ADDR, 8'h81);
    @(posedge sys_clk) #1;
    chk(prog_ready_irq, 1'b0);
    idle_wait();
    global_irq_enable = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1;
    chk(prog_ready_irq, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, reg_wr, reg_rd, reg_io_space, global_irq_enable} = '0;
    {reg_addr, reg_wdata, boot_size_fuse, buffer_index} = '0;
    fuse_high = 8'hA6;
    signature_byte = 8'h3C;
    repeat (16) @(posedge sys_clk);
    #1;
    resetn = 1'b1;
    t_regs();
    t_page();
    t_erase();
    t_abort();
    t_lock();
    t_irq();
    finish_test();
  end
endmodule // tb_flash_self_program_ctrl
`default_nettype wire
